// ---- core/rtcp_timer.sv ----
// Reload timer with input capture, capture-with-reset, external load and
// PWM output, reached by software over an AHB-Lite slave port.
// Assumes one clock hclk at 250 MHz; the timer input pin is asynchronous.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rtcp_regs.svh"

// Overview of operation
// - In the capture modes the counter counts up by one on every prescaler output tick.
// - In the capture modes an enabled input edge copies the count to the capture register, sets the event flag and may request an interrupt.
// - The event flag stays set until software clears it.
// - Overflow drives the output pin high and a compare match drives it low and sets the match flag.
// - A compare match requests an interrupt only while the compare interrupt enable is set.
// - The compare match flag stays set until software clears it.
// - The prescaler sets the PWM period and the compare register sets its duty cycle.
// - Two clock-select bits and three prescale-select bits in control register one steer the clock.
// - In capture-with-reset mode each capture also clears the counter and the prescaler.
// - In external-load mode an enabled input edge loads the capture register into the counter.
// - Every load of the counter also resets the prescaler.
// - Writing 06h to status register zero clears only the overflow flag.
// - An interrupt arriving during service is held and taken afterwards.
module rtcp_timer
    import rtcp_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer pins
    input wire logic timer_input_pin,
    output logic timer_output_pin,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Hardware set wins over a clear arriving in the same cycle.
    function automatic logic [2:0] flag_update(input logic [2:0] old_val,
                                               input logic [2:0] set_bits,
                                               input logic [2:0] clr_bits);
        flag_update = (old_val & ~clr_bits) | set_bits;
    endfunction : flag_update

    function automatic logic [6:0] presc_mask(input logic [2:0] sel);
        logic [7:0] ones;
        ones = (8'h01 << sel) - 8'h01;
        presc_mask = ones[6:0];
    endfunction : presc_mask

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    rtcp_mode_ctrl_t timer_mode_ctrl;
    rtcp_sc_one_t status_ctrl_one;
    logic [2:0] status_ctrl_zero;
    logic [7:0] capture_reload_reg;
    logic [7:0] compare_value_reg;
    logic [7:0] load_value_reg;
    logic [7:0] up_counter;
    logic [6:0] prescaler;
    logic [1:0] div3_count;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    rtcp_ahb_phase_t data_phase;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic addr_phase;
    logic wr_active;
    logic [7:0] wbyte;
    logic wr_mode;
    logic wr_sc0;
    logic wr_sc1;
    logic wr_capture;
    logic wr_compare;
    logic wr_load;
    logic wr_counter;
    logic wr_irq_status;
    logic wr_irq_mask;
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_active = data_phase.valid && data_phase.write;
    assign wbyte = hwdata[7:0];
    assign wr_mode = wr_active && (data_phase.addr == `RTCP_OFS_MODE_CTRL);
    assign wr_sc0 = wr_active && (data_phase.addr == `RTCP_OFS_SC_ZERO);
    assign wr_sc1 = wr_active && (data_phase.addr == `RTCP_OFS_SC_ONE);
    assign wr_capture = wr_active && (data_phase.addr == `RTCP_OFS_CAPTURE);
    assign wr_compare = wr_active && (data_phase.addr == `RTCP_OFS_COMPARE);
    assign wr_load = wr_active && (data_phase.addr == `RTCP_OFS_LOAD);
    assign wr_counter = wr_active && (data_phase.addr == `RTCP_OFS_COUNTER);
    assign wr_irq_status = wr_active && (data_phase.addr == `RTCP_OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_active && (data_phase.addr == `RTCP_OFS_IRQ_MASK);

    // Every transfer completes with no wait state and an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_phase <= '0;
        end else if (hready) begin
            data_phase.valid <= addr_phase;
            data_phase.write <= hwrite;
            data_phase.addr <= {haddr[11:2], 2'b00};
        end
    end

    // Read data is sampled in the address phase, so a read that directly
    // follows a write to the same register returns the value before the write.
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr[11:0] == `RTCP_OFS_MODE_CTRL) begin
            next_rdata[7:0] = timer_mode_ctrl;
        end else if (haddr[11:0] == `RTCP_OFS_SC_ZERO) begin
            next_rdata[2:0] = status_ctrl_zero;
        end else if (haddr[11:0] == `RTCP_OFS_SC_ONE) begin
            next_rdata[7:0] = status_ctrl_one;
        end else if (haddr[11:0] == `RTCP_OFS_CAPTURE) begin
            next_rdata[7:0] = capture_reload_reg;
        end else if (haddr[11:0] == `RTCP_OFS_COMPARE) begin
            next_rdata[7:0] = compare_value_reg;
        end else if (haddr[11:0] == `RTCP_OFS_LOAD) begin
            next_rdata[7:0] = load_value_reg;
        end else if (haddr[11:0] == `RTCP_OFS_COUNTER) begin
            next_rdata[7:0] = up_counter;
        end else if (haddr[11:0] == `RTCP_OFS_IRQ_STATUS) begin
            next_rdata[2:0] = irq_status;
        end else if (haddr[11:0] == `RTCP_OFS_IRQ_MASK) begin
            next_rdata[2:0] = irq_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_mode_ctrl <= `RTCP_RST_BYTE;
            status_ctrl_one <= `RTCP_RST_BYTE;
            compare_value_reg <= `RTCP_RST_BYTE;
            load_value_reg <= `RTCP_RST_BYTE;
            irq_mask <= `RTCP_RST_FLAGS;
        end else begin
            if (wr_mode) begin
                timer_mode_ctrl <= wbyte & `RTCP_MODE_WMASK;
            end
            if (wr_sc1) begin
                status_ctrl_one <= wbyte & `RTCP_SC1_WMASK;
            end
            if (wr_compare) begin
                compare_value_reg <= wbyte;
            end
            if (wr_load) begin
                load_value_reg <= wbyte;
            end
            if (wr_irq_mask) begin
                irq_mask <= wbyte[2:0] & `RTCP_IRQ_WMASK;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input pin synchroniser and edge detect
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= timer_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic pin_rise;
    logic pin_fall;
    logic edge_hit;
    logic capture_mode;
    logic capture_event;
    logic cap_reset_event;
    logic ext_load_event;
    assign pin_rise = pin_sync && !pin_prev;
    assign pin_fall = !pin_sync && pin_prev;
    // Low select bit arms rising edges, high select bit arms falling edges.
    assign edge_hit = (status_ctrl_one.edge_sel_lo && pin_rise)
                      || (status_ctrl_one.edge_sel_hi && pin_fall);
    assign capture_mode = (timer_mode_ctrl.mode == RTCP_MODE_CAPTURE)
                          || (timer_mode_ctrl.mode == RTCP_MODE_CAP_RESET);
    assign capture_event = capture_mode && edge_hit;
    assign cap_reset_event = edge_hit && (timer_mode_ctrl.mode == RTCP_MODE_CAP_RESET);
    assign ext_load_event = edge_hit && (timer_mode_ctrl.mode == RTCP_MODE_EXT_LOAD);

    // ------------------------------------------------------------------------
    // Clock source and prescaler
    // ------------------------------------------------------------------------
    logic src_tick;
    logic count_tick;
    logic counter_load;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div3_count <= 2'h0;
        end else if (div3_count == `RTCP_DIV3_LAST) begin
            div3_count <= 2'h0;
        end else begin
            div3_count <= div3_count + 2'h1;
        end
    end

    // The pin source is only meant for auto-reload mode; software keeps to
    // the internal sources in the other modes and never switches while running.
    always_comb begin
        case (status_ctrl_one.clk_sel)
            RTCP_CLK_INT: src_tick = 1'b1;
            RTCP_CLK_DIV3: src_tick = (div3_count == `RTCP_DIV3_LAST);
            RTCP_CLK_PIN: src_tick = pin_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // The prescaler output ticks once every 2 to the power prescale_sel
    // source ticks, which sets the PWM period.
    assign count_tick = src_tick
        && ((prescaler & presc_mask(status_ctrl_one.prescale_sel))
            == presc_mask(status_ctrl_one.prescale_sel));
    logic overflow_event;
    logic reload_event;
    assign overflow_event = count_tick && (up_counter == `RTCP_COUNT_MAX);
    assign reload_event = overflow_event && (timer_mode_ctrl.mode == RTCP_MODE_RELOAD);
    assign counter_load = wr_counter || ext_load_event || cap_reset_event || reload_event;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler <= `RTCP_RST_PRESC;
        end else if (counter_load) begin
            prescaler <= `RTCP_RST_PRESC;
        end else if (src_tick) begin
            prescaler <= prescaler + 7'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    logic [7:0] next_count;
    always_comb begin
        next_count = up_counter;
        if (wr_counter) begin
            next_count = wbyte;
        end else if (ext_load_event) begin
            next_count = capture_reload_reg;
        end else if (cap_reset_event) begin
            next_count = 8'h00;
        end else if (reload_event) begin
            next_count = load_value_reg;
        end else if (count_tick) begin
            next_count = up_counter + 8'h01;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_counter <= `RTCP_RST_BYTE;
        end else begin
            up_counter <= next_count;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_reload_reg <= `RTCP_RST_BYTE;
        end else if (capture_event) begin
            capture_reload_reg <= up_counter;
        end else if (wr_capture) begin
            capture_reload_reg <= wbyte;
        end
    end

    // ------------------------------------------------------------------------
    // Compare, PWM output and flags
    // ------------------------------------------------------------------------
    logic compare_event;
    assign compare_event = count_tick && !counter_load
                           && (next_count == compare_value_reg);

    // Outside auto-reload mode a match on the same tick as the overflow wins, so
    // there a compare value of zero holds the output low; a reload masks the match.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_output_pin <= 1'b0;
        end else if (compare_event) begin
            timer_output_pin <= 1'b0;
        end else if (overflow_event) begin
            timer_output_pin <= 1'b1;
        end
    end

    rtcp_events_t hw_events;
    assign hw_events.capture = capture_event || ext_load_event;
    assign hw_events.compare = compare_event;
    assign hw_events.overflow = overflow_event;
    logic [2:0] sc0_set;
    logic [2:0] sc0_clr;
    always_comb begin
        sc0_set = 3'h0;
        sc0_set[`RTCP_SC0_OVF_BIT] = hw_events.overflow;
        sc0_set[`RTCP_SC0_EF_BIT] = hw_events.capture;
        sc0_set[`RTCP_SC0_CPF_BIT] = hw_events.compare;
    end
    // Writing a zero clears a flag and a one leaves it, so 06h clears only
    // the overflow flag and a capture racing the write is never lost.
    assign sc0_clr = wr_sc0 ? ~wbyte[2:0] : 3'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ctrl_zero <= `RTCP_RST_FLAGS;
        end else begin
            status_ctrl_zero <= flag_update(status_ctrl_zero, sc0_set, sc0_clr);
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------------
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    assign irq_set = {hw_events.capture && timer_mode_ctrl.external_irq_enable,
                      hw_events.compare && timer_mode_ctrl.compare_irq_enable,
                      hw_events.overflow && timer_mode_ctrl.overflow_irq_enable};
    assign irq_clr = wr_irq_status ? wbyte[2:0] : 3'h0;
    // Requests stay pending while another is serviced and raise the line
    // again as soon as the earlier one is cleared.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= `RTCP_RST_FLAGS;
        end else begin
            irq_status <= flag_update(irq_status, irq_set, irq_clr);
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule : rtcp_timer
`default_nettype wire

// ---- include/rtcp_regs.svh ----
// Register offsets, field positions, reset values and counts for the
// reload timer with capture and PWM.
// Assumes a 32-bit AHB-Lite slave where each register takes one aligned word.
`ifndef RTCP_REGS_SVH
`define RTCP_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTCP_OFS_MODE_CTRL 12'h000
`define RTCP_OFS_SC_ZERO 12'h004
`define RTCP_OFS_SC_ONE 12'h008
`define RTCP_OFS_CAPTURE 12'h00C
`define RTCP_OFS_COMPARE 12'h010
`define RTCP_OFS_LOAD 12'h014
`define RTCP_OFS_COUNTER 12'h018
`define RTCP_OFS_IRQ_STATUS 12'h01C
`define RTCP_OFS_IRQ_MASK 12'h020

// ----------------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------------
`define RTCP_SC0_OVF_BIT 0
`define RTCP_SC0_EF_BIT 1
`define RTCP_SC0_CPF_BIT 2
`define RTCP_MODE_WMASK 8'h37
`define RTCP_SC1_WMASK 8'h7F
`define RTCP_IRQ_WMASK 3'h7

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define RTCP_RST_BYTE 8'h00
`define RTCP_RST_FLAGS 3'h0
`define RTCP_RST_PRESC 7'h00
`define RTCP_COUNT_MAX 8'hFF
`define RTCP_DIV3_LAST 2'h2

`endif

// ---- include/rtcp_pkg.sv ----
// Types shared by the reload timer with capture and PWM.
// Assumes rtcp_regs.svh supplies the numeric constants.
package rtcp_pkg;

    // ------------------------------------------------------------------------
    // Modes and clock sources
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RTCP_MODE_RELOAD,
        RTCP_MODE_CAPTURE,
        RTCP_MODE_CAP_RESET,
        RTCP_MODE_EXT_LOAD
    } rtcp_mode_t;

    typedef enum logic [1:0] {
        RTCP_CLK_STOP,
        RTCP_CLK_INT,
        RTCP_CLK_DIV3,
        RTCP_CLK_PIN
    } rtcp_clk_src_t;

    // ------------------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] unused_hi;
        rtcp_mode_t mode;
        logic unused_lo;
        logic external_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
    } rtcp_mode_ctrl_t;

    typedef struct packed {
        logic unused;
        logic [2:0] prescale_sel;
        rtcp_clk_src_t clk_sel;
        logic edge_sel_hi;
        logic edge_sel_lo;
    } rtcp_sc_one_t;

    typedef struct packed {
        logic capture;
        logic compare;
        logic overflow;
    } rtcp_events_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } rtcp_ahb_phase_t;

endpackage : rtcp_pkg

// ---- test/rtcp_timer_sva.sv ----
// Concurrent checks on the bus, timer output pin and interrupt of the reload timer.
// Assumes a single slave on the bus, so hready follows hreadyout.
`timescale 1ns/1ns
`default_nettype none
module rtcp_timer_sva (
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins and interrupt
    input wire logic timer_input_pin,
    input wire logic timer_output_pin,
    input wire logic irq
);
    wire logic taken = hsel && htrans[1] && hready;
    logic rd_q;
    logic wr_q;
    logic [9:0] ra_q;
    logic [2:1] seen;
    logic mask_zero;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'h0;
            wr_q <= 1'h0;
            ra_q <= 10'h000;
        end else begin
            rd_q <= taken && !hwrite;
            wr_q <= taken && hwrite;
            ra_q <= haddr[11:2];
        end
    end

    // The event or match flag once read as set must read set until a write clears it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen <= 2'h0;
        end else if (wr_q && ra_q == 10'h001) begin
            seen <= seen & hwdata[2:1];
        end else if (rd_q && ra_q == 10'h001) begin
            seen <= seen | hrdata[2:1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_zero <= 1'h1;
        end else if (wr_q && ra_q == 10'h008) begin
            mask_zero <= (hwdata[2:0] == 3'h0);
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_rdata_narrow: assert property (hrdata[31:8] == 24'h000000)
        else $error("hrdata upper bits set");
    chk_unmapped_zero: assert property (taken && !hwrite && haddr[11:2] > 10'h008 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    chk_event_sticky: assert property (rd_q && ra_q == 10'h001 && seen[1]
        |-> hrdata[1])
        else $error("event flag lost");
    chk_match_sticky: assert property (rd_q && ra_q == 10'h001 && seen[2]
        |-> hrdata[2])
        else $error("match flag lost");
    chk_mask_blocks: assert property (mask_zero |-> !irq)
        else $error("irq while fully masked");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !timer_output_pin && !irq)
        else $error("outputs active after reset");
endmodule : rtcp_timer_sva

bind rtcp_timer rtcp_timer_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_input_pin(timer_input_pin),
    .timer_output_pin(timer_output_pin), .irq(irq));
`default_nettype wire

// ---- test/rtcp_pin_model.sv ----
// Model of the external event source that drives the timer input pin.
// Assumes it shares the bus clock and that the pin idles low between events.
`timescale 1ns/1ns
`default_nettype none
module rtcp_pin_model (
    // Clock
    input wire logic hclk,
    // Event pin
    output logic timer_input_pin
);
    initial timer_input_pin = 1'h0;

    // Each level is held n cycles; the input synchroniser needs one at least.
    task automatic pulse(input int n);
        timer_input_pin <= 1'h1;
        repeat (n) @(posedge hclk);
        timer_input_pin <= 1'h0;
        repeat (n) @(posedge hclk);
    endtask : pulse
endmodule : rtcp_pin_model
`default_nettype wire

// ---- test/rtcp_timer_tb.sv ----
// Self-checking testbench for the reload timer, driven over AHB-Lite.
// Assumes the pin model as event source and hready looped from hreadyout.
`timescale 1ns/1ns
`default_nettype none
`include "rtcp_regs.svh"
module rtcp_timer_tb;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic timer_input_pin;
    wire logic timer_output_pin;
    wire logic irq;
    int fails = 0;
    int checks = 0;
    int hi;
    int lo;
    logic [31:0] cap_cfg [3] = '{32'h01, 32'h00, 32'h02};
    logic [31:0] cap_cnt [3] = '{32'h5A, 32'h33, 32'h44};
    logic [31:0] cap_exp [3] = '{32'h5A, 32'h5A, 32'h44};
    logic [31:0] pwm_cfg [3] = '{32'h04, 32'h14, 32'h08};
    int pwm_div [3] = '{1, 2, 3};

    initial begin
        hclk = 1'h0;
        forever #2 hclk = ~hclk;
    end

    rtcp_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin), .irq(irq));
    rtcp_pin_model pin (.hclk(hclk), .timer_input_pin(timer_input_pin));

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One idle edge closes every transfer so a following read sees the update.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        haddr <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        @(posedge hclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'h1, a, d, unused);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'h0, a, 32'h0, d);
        chk(d & m, e);
    endtask : rdc

    task automatic event_pulse();
        pin.pulse(4);
        repeat (4) @(posedge hclk);
    endtask : event_pulse

    // Times one high and one low stretch of the output, sampled on falling edges.
    task automatic meas(output int h, output int l);
        int k;
        k = 0;
        h = 0;
        l = 0;
        while (timer_output_pin !== 1'h0 && k < 5000) begin @(negedge hclk); k++; end
        while (timer_output_pin !== 1'h1 && k < 5000) begin @(negedge hclk); k++; end
        while (timer_output_pin === 1'h1 && k < 5000) begin @(negedge hclk); k++; h++; end
        while (timer_output_pin === 1'h0 && k < 5000) begin @(negedge hclk); k++; l++; end
        @(posedge hclk);
    endtask : meas

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        give_verdict();
    end

    initial begin
        hresetn = 1'h0;
        hsel = 1'h1;
        hwrite = 1'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int a = 0; a <= 12; a++) rdc(12'(a * 4), 32'hFFFFFFFF, 32'h0);
        $display("test reset values done");
        wr(`RTCP_OFS_MODE_CTRL, 32'h14);
        wr(`RTCP_OFS_IRQ_MASK, 32'h04);
        for (int i = 0; i < 3; i++) begin
            wr(`RTCP_OFS_SC_ONE, cap_cfg[i]);
            wr(`RTCP_OFS_COUNTER, cap_cnt[i]);
            event_pulse();
            rdc(`RTCP_OFS_CAPTURE, 32'hFF, cap_exp[i]);
        end
        rdc(`RTCP_OFS_SC_ZERO, 32'hFF, 32'h02);
        chk({31'h0, irq}, 32'h1);
        wr(`RTCP_OFS_IRQ_MASK, 32'h00);
        chk({31'h0, irq}, 32'h0);
        wr(`RTCP_OFS_IRQ_MASK, 32'h04);
        chk({31'h0, irq}, 32'h1);
        wr(`RTCP_OFS_SC_ZERO, 32'h06);
        rdc(`RTCP_OFS_SC_ZERO, 32'hFF, 32'h02);
        wr(`RTCP_OFS_SC_ZERO, 32'h00);
        rdc(`RTCP_OFS_SC_ZERO, 32'hFF, 32'h00);
        wr(`RTCP_OFS_IRQ_STATUS, 32'h07);
        chk({31'h0, irq}, 32'h0);
        $display("test capture done");
        wr(`RTCP_OFS_MODE_CTRL, 32'h20);
        wr(`RTCP_OFS_SC_ONE, 32'h01);
        wr(`RTCP_OFS_COUNTER, 32'h55);
        event_pulse();
        rdc(`RTCP_OFS_COUNTER, 32'hFF, 32'h00);
        rdc(`RTCP_OFS_CAPTURE, 32'hFF, 32'h55);
        wr(`RTCP_OFS_MODE_CTRL, 32'h30);
        wr(`RTCP_OFS_CAPTURE, 32'h9A);
        wr(`RTCP_OFS_COUNTER, 32'h11);
        event_pulse();
        rdc(`RTCP_OFS_COUNTER, 32'hFF, 32'h9A);
        $display("test reset and load done");
        wr(`RTCP_OFS_MODE_CTRL, 32'h10);
        wr(`RTCP_OFS_COMPARE, 32'h80);
        wr(`RTCP_OFS_LOAD, 32'h40);
        wr(`RTCP_OFS_IRQ_MASK, 32'h02);
        for (int i = 0; i < 3; i++) begin
            wr(`RTCP_OFS_SC_ONE, 32'h00);
            wr(`RTCP_OFS_SC_ONE, pwm_cfg[i]);
            meas(hi, lo);
            chk(32'(hi), 32'(128 * pwm_div[i]));
            chk(32'(lo), 32'(128 * pwm_div[i]));
        end
        rdc(`RTCP_OFS_IRQ_STATUS, 32'hFF, 32'h00);
        chk({31'h0, irq}, 32'h0);
        wr(`RTCP_OFS_SC_ONE, 32'h00);
        rdc(`RTCP_OFS_SC_ZERO, 32'hFF, 32'h07);
        wr(`RTCP_OFS_SC_ZERO, 32'h06);
        rdc(`RTCP_OFS_SC_ZERO, 32'hFF, 32'h06);
        wr(`RTCP_OFS_SC_ONE, 32'h08);
        wr(`RTCP_OFS_MODE_CTRL, 32'h12);
        meas(hi, lo);
        rdc(`RTCP_OFS_IRQ_STATUS, 32'h02, 32'h02);
        chk({31'h0, irq}, 32'h1);
        wr(`RTCP_OFS_MODE_CTRL, 32'h00);
        meas(hi, lo);
        chk(32'(hi), 32'(64 * 3));
        chk(32'(lo), 32'(128 * 3));
        $display("test pwm done");
        give_verdict();
    end
endmodule : rtcp_timer_tb
`default_nettype wire
